// ===== pkg/cwg_pkg.sv
// Package with constants and carrier types for the compare waveform generator.
package cwg_pkg;

	// Number of channels and counter width.
	localparam int          NUM_CH     = 8;
	localparam int          TW         = 16;
	// Counter value at which every single-phase output returns to its default level.
	localparam logic [15:0] TIMER_ZERO = 16'h0000;
	// Output level after reset.
	localparam logic        OUT_RESET  = 1'b0;
	// Reset-select patterns: {on reset register match, select b, on channel 0 match}.
	localparam logic [2:0]  RSEL_NONE  = 3'h0;
	localparam logic [2:0]  RSEL_CH0   = 3'h1;
	localparam logic [2:0]  RSEL_RREG  = 3'h4;

	// Output waveform mode field encodings.
	typedef enum logic [1:0] {
		CWG_MODE_SINGLE = 2'h0,
		CWG_MODE_PHASE  = 2'h1,
		CWG_MODE_SR     = 2'h2,
		CWG_MODE_RSVD   = 2'h3
	} cwg_mode_t;

	// Per-channel output control settings.
	typedef struct packed {
		cwg_mode_t waveform_mode_field;
		logic      default_level_bit;
		logic      compare_reload_timing_bit;
		logic      output_invert_bit;
	} cwg_ctrl_t;

endpackage

// ===== hw/cwg_top.sv
// Eight-channel compare waveform generator with its shared base timer.
`timescale 1ns/100ps

// Summary of operation
// - Channel events fire on timer-compare equality.
// - Mode field picks single; phase and set/reset only hold the level.
// - Waveform function needs function select zero.
// - Enable bit one starts channel output.
// - Enable bit zero stops channel output.
// - Single-phase output leaves its default level on compare match.
// - Single-phase output returns to its default level when timer is zero.
// - Free-running period is 65536 clocks.
// - Timer clears on channel 0 match.
// - Timer clears on reset register match.
// - Reset-match period is n plus two.
// - Match sets interrupt request flag of a channel with enable one and function select zero.
// - Default-level bit sets level before match.
// - Invert bit inverts the driven waveform.
// - Reload bit picks when new compare applies.
module cwg_top
(
	// Clock and reset.
	input  wire logic                                      CLOCK,
	input  wire logic                                      NRST,
	// Base timer configuration.
	input  wire logic                                      TIMER_RUN,
	input  wire logic [2:0]                                RESET_SELECT,
	input  wire logic [15:0]                               BASE_TIMER_RESET_VALUE,
	// Channel configuration.
	input  wire logic [cwg_pkg::NUM_CH-1:0][15:0]          CHANNEL_COMPARE_VALUE,
	input  cwg_pkg::cwg_ctrl_t [cwg_pkg::NUM_CH-1:0]       CHANNEL_OUTPUT_CONTROL,
	input  wire logic [cwg_pkg::NUM_CH-1:0]                CHANNEL_FUNCTION_SELECT_BIT,
	input  wire logic [cwg_pkg::NUM_CH-1:0]                CHANNEL_ENABLE_BIT,
	// Interrupt flag clear, one bit per channel.
	input  wire logic [cwg_pkg::NUM_CH-1:0]                IRQ_CLEAR,
	// Status and pins.
	output logic      [15:0]                               BASE_TIMER_COUNT,
	output logic      [cwg_pkg::NUM_CH-1:0]                CHANNEL_IRQ_FLAG,
	output logic      [cwg_pkg::NUM_CH-1:0]                WAVEFORM_OUTPUT_PIN
);

	// Base timer state.
	logic [15:0]                    timer_r;
	logic [15:0]                    timer_nxt;
	// Interrupt flags.
	logic [cwg_pkg::NUM_CH-1:0]     irq_r;
	logic [cwg_pkg::NUM_CH-1:0]     irq_nxt;
	// Raw waveform level per channel, before inversion.
	logic [cwg_pkg::NUM_CH-1:0]     wave_r;
	logic [cwg_pkg::NUM_CH-1:0]     wave_nxt;
	// Pin register, after inversion.
	logic [cwg_pkg::NUM_CH-1:0]     pin_r;
	logic [cwg_pkg::NUM_CH-1:0]     pin_nxt;
	// Active compare value per channel.
	logic [cwg_pkg::NUM_CH-1:0][15:0] cmp_r;
	logic [cwg_pkg::NUM_CH-1:0][15:0] cmp_nxt;
	// Previous enable, to see a fresh enable.
	logic [cwg_pkg::NUM_CH-1:0]     en_r;
	// Match strobes.
	logic [cwg_pkg::NUM_CH-1:0]     match;
	logic                           rreg_match;
	logic                           timer_clear;

	// Channel is a running waveform generator.
	logic [cwg_pkg::NUM_CH-1:0]     active;

	// Match and activity decode; a match counts only while the timer runs.
	always_comb
	begin
		for (int i = 0; i < cwg_pkg::NUM_CH; i++)
		begin
			match[i]  = TIMER_RUN && (timer_r == cmp_r[i]);
			active[i] = CHANNEL_ENABLE_BIT[i] && !CHANNEL_FUNCTION_SELECT_BIT[i];
		end
		rreg_match = TIMER_RUN && (timer_r == BASE_TIMER_RESET_VALUE);
	end

	// Base timer next value. The clear lands one clock after the match so the
	// cycle is n+2 long: n, n+1, then zero.
	logic clear_pend_r;
	logic clear_pend_nxt;
	always_comb
	begin
		clear_pend_nxt = 1'b0;
		if (RESET_SELECT == cwg_pkg::RSEL_CH0)
		begin
			clear_pend_nxt = match[0];
		end
		else if (RESET_SELECT == cwg_pkg::RSEL_RREG)
		begin
			clear_pend_nxt = rreg_match;
		end
		timer_clear = clear_pend_r;
		if (!TIMER_RUN)
		begin
			timer_nxt = timer_r;
		end
		else if (timer_clear)
		begin
			timer_nxt = cwg_pkg::TIMER_ZERO;
		end
		else
		begin
			timer_nxt = timer_r + 16'h0001;
		end
	end

	// Timer registers.
	always_ff @(posedge CLOCK)
	begin
		if (!NRST)
		begin
			timer_r      <= cwg_pkg::TIMER_ZERO;
			clear_pend_r <= 1'b0;
		end
		else
		begin
			timer_r      <= timer_nxt;
			clear_pend_r <= clear_pend_nxt;
		end
	end

	// Per-channel next state. Compare reload: bit clear loads at once, bit set
	// waits for the timer to reach zero while the channel runs, so a period is never cut short.
	always_comb
	begin
		for (int i = 0; i < cwg_pkg::NUM_CH; i++)
		begin
			cmp_nxt[i] = cmp_r[i];
			if (!CHANNEL_OUTPUT_CONTROL[i].compare_reload_timing_bit
				|| timer_r == cwg_pkg::TIMER_ZERO || !active[i])
			begin
				cmp_nxt[i] = CHANNEL_COMPARE_VALUE[i];
			end
			// Set wins over the clear so no match is lost. A match counts only from the
			// second enabled cycle, so a compare copy that still holds its reset value
			// cannot raise a flag in the very first cycle after reset.
			irq_nxt[i] = (irq_r[i] && !IRQ_CLEAR[i])
				|| (active[i] && en_r[i] && match[i]);
			if (!active[i] || !en_r[i])
			begin
				// Held, and reloaded on a fresh enable.
				wave_nxt[i] = CHANNEL_OUTPUT_CONTROL[i].default_level_bit;
			end
			else
			begin
				case (CHANNEL_OUTPUT_CONTROL[i].waveform_mode_field)
					cwg_pkg::CWG_MODE_SINGLE:
					begin
						if (timer_nxt == cwg_pkg::TIMER_ZERO)
						begin
							wave_nxt[i] = CHANNEL_OUTPUT_CONTROL[i].default_level_bit;
						end
						else if ((TIMER_RUN && timer_nxt == cmp_nxt[i]) || match[i])
						begin
							// Looking at the next count makes the pin change together with
							// the count, so the default level lasts exactly m clocks. The
							// plain match only catches a channel enabled too late to look.
							wave_nxt[i] = !CHANNEL_OUTPUT_CONTROL[i].default_level_bit;
						end
						else
						begin
							wave_nxt[i] = wave_r[i];
						end
					end
					// Phase and set/reset modes are not implemented; the level simply holds here.
					default:
					begin
						wave_nxt[i] = wave_r[i];
					end
				endcase
			end
			pin_nxt[i] = wave_nxt[i] ^ CHANNEL_OUTPUT_CONTROL[i].output_invert_bit;
		end
	end

	// Channel registers.
	always_ff @(posedge CLOCK)
	begin
		if (!NRST)
		begin
			cmp_r  <= '0;
			irq_r  <= '0;
			wave_r <= '0;
			pin_r  <= {cwg_pkg::NUM_CH{cwg_pkg::OUT_RESET}};
			en_r   <= '0;
		end
		else
		begin
			cmp_r  <= cmp_nxt;
			irq_r  <= irq_nxt;
			wave_r <= wave_nxt;
			pin_r  <= pin_nxt;
			en_r   <= active;
		end
	end

	// Outputs come straight from flip-flops.
	assign BASE_TIMER_COUNT    = timer_r;
	assign CHANNEL_IRQ_FLAG    = irq_r;
	assign WAVEFORM_OUTPUT_PIN = pin_r;

endmodule

// ===== dv/cwg_properties.sv
// Port checker for the waveform generator, watching the timer and channel 1.
`timescale 1ns/100ps
module cwg_check
(
	// Clock, reset and timer.
	input wire logic                 CLOCK,
	input wire logic                 NRST,
	input wire logic                 TIMER_RUN,
	input wire logic [2:0]           RESET_SELECT,
	input wire logic [15:0]          BASE_TIMER_RESET_VALUE,
	input wire logic [15:0]          BASE_TIMER_COUNT,
	// Channels.
	input wire logic [7:0][15:0]     CHANNEL_COMPARE_VALUE,
	input cwg_pkg::cwg_ctrl_t [7:0]  CHANNEL_OUTPUT_CONTROL,
	input wire logic [7:0]           CHANNEL_FUNCTION_SELECT_BIT,
	input wire logic [7:0]           CHANNEL_ENABLE_BIT,
	input wire logic [7:0]           CHANNEL_IRQ_FLAG,
	input wire logic [7:0]           WAVEFORM_OUTPUT_PIN
);
	// The first enabled cycle never matches, so a channel counts only from its second.
	logic               act_r;
	cwg_pkg::cwg_ctrl_t c;
	wire                on  = CHANNEL_ENABLE_BIT[1] & ~CHANNEL_FUNCTION_SELECT_BIT[1];
	assign c = CHANNEL_OUTPUT_CONTROL[1];
	wire                lv  = c.default_level_bit ^ c.output_invert_bit;
	wire                g   = on & act_r & (c.waveform_mode_field == cwg_pkg::CWG_MODE_SINGLE);
	wire                hit = g & TIMER_RUN & (BASE_TIMER_COUNT == CHANNEL_COMPARE_VALUE[1]);
	// Remembers that channel 1 was running in the cycle before.
	always_ff @(posedge CLOCK)
	begin
		act_r <= on & NRST;
	end
	default clocking @(posedge CLOCK); endclocking
	default disable iff (!NRST);
	a_match_flag: assert property (hit |=> CHANNEL_IRQ_FLAG[1])
		else $error("match left flag clear");
	// A pin seen after an edge was computed from the settings before that edge.
	a_match_pin: assert property (hit |=> WAVEFORM_OUTPUT_PIN[1] != $past(lv))
		else $error("match did not flip pin");
	a_zero_default: assert property (g && TIMER_RUN && BASE_TIMER_COUNT == cwg_pkg::TIMER_ZERO
		|-> WAVEFORM_OUTPUT_PIN[1] == $past(lv)) else $error("pin not default at zero");
	a_idle_level: assert property (!on |=> WAVEFORM_OUTPUT_PIN[1] == $past(lv))
		else $error("idle pin not default");
	a_idle_noflag: assert property (!on && !CHANNEL_IRQ_FLAG[1] |=> !CHANNEL_IRQ_FLAG[1])
		else $error("idle channel set flag");
	a_free_count: assert property (TIMER_RUN && RESET_SELECT == cwg_pkg::RSEL_NONE
		|=> BASE_TIMER_COUNT == $past(BASE_TIMER_COUNT) + 16'h0001) else $error("timer step");
	a_ch0_clear: assert property (RESET_SELECT == cwg_pkg::RSEL_CH0 && TIMER_RUN
		&& BASE_TIMER_COUNT == CHANNEL_COMPARE_VALUE[0] ##1 TIMER_RUN
		|=> BASE_TIMER_COUNT == 16'h0000) else $error("no clear on ch0");
	a_rreg_clear: assert property (RESET_SELECT == cwg_pkg::RSEL_RREG && TIMER_RUN
		&& BASE_TIMER_COUNT == BASE_TIMER_RESET_VALUE ##1 TIMER_RUN
		|=> BASE_TIMER_COUNT == 16'h0000) else $error("no clear on reset value");
endmodule
bind cwg_top cwg_check u_chk (
	.CLOCK                       (CLOCK),
	.NRST                        (NRST),
	.TIMER_RUN                   (TIMER_RUN),
	.RESET_SELECT                (RESET_SELECT),
	.BASE_TIMER_RESET_VALUE      (BASE_TIMER_RESET_VALUE),
	.BASE_TIMER_COUNT            (BASE_TIMER_COUNT),
	.CHANNEL_COMPARE_VALUE       (CHANNEL_COMPARE_VALUE),
	.CHANNEL_OUTPUT_CONTROL      (CHANNEL_OUTPUT_CONTROL),
	.CHANNEL_FUNCTION_SELECT_BIT (CHANNEL_FUNCTION_SELECT_BIT),
	.CHANNEL_ENABLE_BIT          (CHANNEL_ENABLE_BIT),
	.CHANNEL_IRQ_FLAG            (CHANNEL_IRQ_FLAG),
	.WAVEFORM_OUTPUT_PIN         (WAVEFORM_OUTPUT_PIN)
);

// ===== dv/test_compare_waveform_generator.sv
// Self-checking bench for the compare waveform generator.
`timescale 1ns/100ps
module test_compare_waveform_generator;
	logic                     clk, nrst, run;
	logic [2:0]               rsel;
	logic [15:0]              rval, cnt;
	logic [7:0][15:0]         cmp;
	cwg_pkg::cwg_ctrl_t [7:0] ctl;
	logic [7:0]               fs, en, clr, irq, pin;
	int                       err_total, n_compared;
	int                       hi;
	cwg_top dut (.CLOCK(clk), .NRST(nrst), .TIMER_RUN(run), .RESET_SELECT(rsel),
		.BASE_TIMER_RESET_VALUE(rval), .CHANNEL_COMPARE_VALUE(cmp), .CHANNEL_OUTPUT_CONTROL(ctl),
		.CHANNEL_FUNCTION_SELECT_BIT(fs), .CHANNEL_ENABLE_BIT(en), .IRQ_CLEAR(clr),
		.BASE_TIMER_COUNT(cnt), .CHANNEL_IRQ_FLAG(irq), .WAVEFORM_OUTPUT_PIN(pin));
	initial
	begin
		clk = 0;
		forever #10 clk = ~clk;
	end
	task automatic chk(input string nm, input logic [15:0] seen, exp);
		n_compared++;
		if (seen !== exp)
		begin
			err_total++;
			$display("[FAIL] %s expected %h seen %h", nm, exp, seen);
		end
	endtask
	task automatic test_done();
		if (err_total == 0 && n_compared > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask
	// Counts high cycles of pin 1 over one whole period, from a timer zero.
	task automatic width(input int p, input logic [15:0] exp);
		int k;
		for (k = 0; cnt !== 16'h0000 && k < 70000; k++)
			@(negedge clk);
		if (cnt !== 16'h0000)
		begin
			chk("timer zero", cnt, 16'h0000);
			test_done();
		end
		k = 0;
		repeat (p)
		begin
			@(negedge clk);
			if (pin[1] === 1'b1)
				k++;
		end
		chk("high width", k[15:0], exp);
	endtask
	initial
	begin
		{nrst, run, fs, clr, ctl, err_total, n_compared} = '0;
		// Base timer first, then the channels; values stay inside the legal range.
		rsel = cwg_pkg::RSEL_NONE;
		rval = 16'h0014;
		cmp = {8{16'h0005}};
		en = 8'hff;
		repeat (16) @(negedge clk);
		nrst = 1;
		run = 1;
		// The count still shows zero here, so one free-running period is measured.
		width(65536, 16'hfffb);
		chk("flags", {8'h00, irq}, 16'h00ff);
		clr = 8'hff;
		@(negedge clk);
		clr = 8'h00;
		cmp[0] = 16'h000a;
		rsel = cwg_pkg::RSEL_CH0;
		width(12, 16'h0007);
		rsel = cwg_pkg::RSEL_RREG;
		width(22, 16'h0011);
		en = 8'hfd;
		ctl[1].output_invert_bit = 1;
		repeat (3) @(negedge clk);
		chk("idle pin", {15'h0000, pin[1]}, 16'h0001);
		en = 8'hff;
		width(22, 16'h0005);
		en = 8'hfd;
		ctl[1] = 5'h04;
		fs = 8'h04;
		clr = 8'h06;
		repeat (3) @(negedge clk);
		clr = 8'h00;
		en = 8'hff;
		width(22, 16'h0005);
		chk("select flag", {15'h0000, irq[2]}, 16'h0000);
		// Reload at zero: a compare written mid-period waits for the next period.
		ctl[1].compare_reload_timing_bit = 1'b1;
		@(negedge clk);
		cmp[1] = 16'h000c;
		hi = 0;
		repeat (21)
		begin
			@(negedge clk);
			if (pin[1] === 1'b1)
				hi++;
		end
		chk("reload hold", hi[15:0], 16'h0004);
		width(22, 16'h000c);
		test_done();
	end
endmodule
